// ===== logic/scs_pkg.sv
package scs_pkg;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_DATA     = 4'h0;
  localparam logic [3:0]  ADDR_CTL      = 4'h4;
  localparam logic [3:0]  ADDR_STAT     = 4'h8;
  localparam logic [3:0]  ADDR_MASK     = 4'hc;

  localparam int          CTL_EN_BIT    = 0;
  localparam int          CTL_DIV_LSB   = 4;
  localparam int          CTL_DIV_W     = 12;
  localparam int          CTL_RETRY_BIT = 19;
  localparam logic [31:0] CTL_RST       = 32'h0000_1740;
  localparam logic [31:0] CTL_WMASK     = 32'h0008_fff1;
  localparam logic [11:0] DIV_MIN       = 12'h002;

  localparam int          ST_RX_OVERRUN_FLAG       = 0;
  localparam int          ST_RX_BUFFER_EMPTY    = 1;
  localparam int          ST_RX_BUFFER_FULL     = 2;
  localparam int          ST_PAR        = 4;
  localparam int          ST_FRM        = 5;
  localparam int          ST_BRK        = 6;
  localparam int          ST_TX_OVERRUN_FLAG       = 8;
  localparam int          ST_TXEMPTY    = 9;
  localparam int          ST_TX_BUFFER_FULL     = 10;
  localparam logic [31:0] W1C_MASK      = 32'h0000_0171;
  localparam logic [31:0] STAT_RST      = 32'h0000_0000;
  localparam logic [31:0] MASK_RST      = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Character framing and buffers
  // ---------------------------------------------------------------
  localparam int          DATA_W        = 8;
  localparam int          BUF_DEPTH     = 4;
  localparam int          BUF_AW        = 2;
  localparam int          BUF_CW        = 3;
  localparam int          CHAR_BITS     = 11;
  localparam logic [3:0]  RX_LAST_BIT   = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT   = 4'h9;
endpackage

// ===== logic/scs_sync2.sv
`timescale 1ns/1ns
module scs_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

// ===== logic/scs_fifo.sv
`timescale 1ns/1ns
module scs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2,
  parameter int CW    = 3
) (
  input  wire logic          i_clk,
  input  wire logic          i_srst,
  input  wire logic          i_push,
  input  wire logic [W-1:0]  i_data,
  input  wire logic          i_pop,
  output logic      [W-1:0]  o_data,
  output logic      [CW-1:0] o_count,
  output logic               o_full,
  output logic               o_empty
);
  import scs_pkg::*;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push_ok;
  logic          pop_ok;

  // Push into a full buffer and pop from an empty one are dropped
  assign push_ok = i_push && !o_full;
  assign pop_ok  = i_pop && !o_empty;
  assign o_full  = (cnt_q == CW'(DEPTH));
  assign o_empty = (cnt_q == '0);
  assign o_count = cnt_q;
  assign o_data  = mem_q[rd_q];

  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push_ok) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop_ok) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push_ok && !pop_ok) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop_ok && !push_ok) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ===== logic/scs_top.sv
// Notes on behaviour
// - Writing data while the transmit buffer is full sets the transmit overrun flag.
// - Transmit full reads one exactly at four buffered bytes, else zero.
// - Overrun, break, stop, parity and receive overrun flags clear only by writing one.
// - Line low longer than one whole character time sets the break flag.
// - A stop bit sampled low sets the stop bit error flag.
// - A received parity bit that mismatches even parity sets the parity flag.
// - With receive retry enabled, break, stop and parity flags are never set.
// - Receive full reads one exactly at four buffered bytes, else zero.
// - Receive empty reads one once the last buffered byte was read out.
// - A byte arriving while the receive buffer is full sets receive overrun.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module scs_top (
  input  wire logic                       I_CLK,
  input  wire logic                       I_SRST,
  input  wire logic [scs_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [31:0]                I_WDATA,
  input  wire logic                       I_WR,
  input  wire logic                       I_RD,
  output logic      [31:0]                O_RDATA,
  input  wire logic                       I_IO_IN,
  output logic                            O_IO_OUT,
  output logic                            O_IO_OE,
  output logic                            O_IRQ
);
  import scs_pkg::*;

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} scs_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_WAIT} scs_rx_e;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic              wr_data;
  logic              wr_ctl;
  logic              wr_stat;
  logic              wr_mask;
  logic              rd_data;
  logic [31:0]       ctl_q;
  logic [31:0]       mask_q;
  logic [31:0]       st_q;
  logic [31:0]       st_d;
  logic [31:0]       stat_w;
  logic [31:0]       ev_vec;
  logic              enable;
  logic              rx_retry_enable;
  logic [11:0]       div_raw;
  logic [11:0]       div_eff;
  logic [11:0]       half_bit;

  assign wr_data = I_WR && (I_ADDR == ADDR_DATA);
  assign wr_ctl  = I_WR && (I_ADDR == ADDR_CTL);
  assign wr_stat = I_WR && (I_ADDR == ADDR_STAT);
  assign wr_mask = I_WR && (I_ADDR == ADDR_MASK);
  assign rd_data = I_RD && (I_ADDR == ADDR_DATA);

  assign enable          = ctl_q[CTL_EN_BIT];
  assign rx_retry_enable = ctl_q[CTL_RETRY_BIT];
  assign div_raw         = ctl_q[CTL_DIV_LSB +: CTL_DIV_W];
  // A divisor below two would make the half-bit wait vanish
  assign div_eff         = (div_raw < DIV_MIN) ? DIV_MIN : div_raw;
  assign half_bit        = div_eff >> 1;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctl_q <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= I_WDATA & CTL_WMASK;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      mask_q <= MASK_RST;
    end else if (wr_mask) begin
      mask_q <= I_WDATA & W1C_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Buffers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] tx_head;
  logic [BUF_CW-1:0] tx_count;
  logic              tx_full;
  logic              tx_empty;
  logic              tx_pop;
  logic [DATA_W-1:0] rx_head;
  logic [BUF_CW-1:0] rx_count;
  logic              rx_full;
  logic              rx_empty;
  logic              rx_push;
  logic [8:0]        rx_sh_q;

  scs_fifo #(.W(DATA_W), .DEPTH(BUF_DEPTH), .AW(BUF_AW), .CW(BUF_CW)) u_tx_buf (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_push  (wr_data),
    .i_data  (I_WDATA[DATA_W-1:0]),
    .i_pop   (tx_pop),
    .o_data  (tx_head),
    .o_count (tx_count),
    .o_full  (tx_full),
    .o_empty (tx_empty)
  );

  scs_fifo #(.W(DATA_W), .DEPTH(BUF_DEPTH), .AW(BUF_AW), .CW(BUF_CW)) u_rx_buf (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_push  (rx_push),
    .i_data  (rx_sh_q[DATA_W-1:0]),
    .i_pop   (rd_data),
    .o_data  (rx_head),
    .o_count (rx_count),
    .o_full  (rx_full),
    .o_empty (rx_empty)
  );

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  scs_tx_e           tx_state_q;
  logic [11:0]       tx_cnt_q;
  logic [3:0]        tx_bit_q;
  logic [9:0]        tx_sh_q;
  logic              tx_tick;

  assign tx_tick = (tx_cnt_q == div_eff - 12'h001);
  assign tx_pop  = (tx_state_q == TX_IDLE) && enable && !tx_empty;

  // Frame is start, eight data, even parity, stop; start goes out on load
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= 12'h000;
      tx_bit_q   <= 4'h0;
      tx_sh_q    <= 10'h3ff;
      O_IO_OUT   <= 1'b1;
      O_IO_OE    <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_state_q <= TX_SHIFT;
            tx_sh_q    <= {1'b1, ^tx_head, tx_head};
            tx_cnt_q   <= 12'h000;
            tx_bit_q   <= 4'h0;
            O_IO_OUT   <= 1'b0;
            O_IO_OE    <= 1'b1;
          end
        end
        TX_SHIFT: begin
          if (!tx_tick) begin
            tx_cnt_q <= tx_cnt_q + 12'h001;
          end else if (tx_bit_q == 4'(CHAR_BITS - 1)) begin
            tx_state_q <= TX_IDLE;
            O_IO_OUT   <= 1'b1;
            O_IO_OE    <= 1'b0;
          end else begin
            tx_cnt_q <= 12'h000;
            tx_bit_q <= tx_bit_q + 4'h1;
            O_IO_OUT <= tx_sh_q[0];
            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  logic              io_s;
  scs_rx_e           rx_state_q;
  logic [11:0]       rx_cnt_q;
  logic [3:0]        rx_bit_q;
  logic              rx_tick;
  logic              ev_char;
  logic              ev_frm;
  logic              ev_par;
  logic              ev_brk;
  logic [15:0]       low_cnt_q;
  logic [15:0]       char_clks;
  logic              line_busy;

  scs_sync2 #(.RST_VAL(1'b1)) u_io_sync (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_d    (I_IO_IN),
    .o_q    (io_s)
  );

  // Own transmission echoes on the shared line and must not be received
  assign line_busy = O_IO_OE;
  assign rx_tick   = (rx_cnt_q == div_eff - 12'h001);
  assign ev_char   = (rx_state_q == RX_STOP) && rx_tick;
  assign ev_frm    = ev_char && !io_s;
  assign ev_par    = ev_char && (^rx_sh_q);
  assign rx_push   = ev_char && !rx_full;
  assign char_clks = 16'(CHAR_BITS) * {4'h0, div_eff};
  // Count reaching the character time with the line still low means longer
  assign ev_brk    = (low_cnt_q == char_clks) && !io_s && enable && !line_busy;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 12'h000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 9'h000;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= 12'h000;
          if (enable && !line_busy && !io_s) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_q != half_bit - 12'h001) begin
            rx_cnt_q <= rx_cnt_q + 12'h001;
          end else begin
            rx_cnt_q   <= 12'h000;
            rx_bit_q   <= 4'h0;
            rx_state_q <= io_s ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (!rx_tick) begin
            rx_cnt_q <= rx_cnt_q + 12'h001;
          end else begin
            rx_cnt_q <= 12'h000;
            rx_sh_q  <= {io_s, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == RX_LAST_BIT) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (!rx_tick) begin
            rx_cnt_q <= rx_cnt_q + 12'h001;
          end else begin
            rx_cnt_q   <= 12'h000;
            rx_state_q <= io_s ? RX_IDLE : RX_WAIT;
          end
        end
        RX_WAIT: begin
          // A low stop bit may be a break; no new start until the line idles
          if (io_s) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Saturates one above the character time so a break reports once
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      low_cnt_q <= 16'h0000;
    end else if (io_s || !enable || line_busy) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q <= char_clks) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Status, interrupt and read data
  // ---------------------------------------------------------------
  always_comb begin
    ev_vec           = 32'h0000_0000;
    ev_vec[ST_TX_OVERRUN_FLAG]  = wr_data && tx_full;
    ev_vec[ST_RX_OVERRUN_FLAG]  = ev_char && rx_full;
    ev_vec[ST_BRK]   = ev_brk && !rx_retry_enable;
    ev_vec[ST_FRM]   = ev_frm && !rx_retry_enable;
    ev_vec[ST_PAR]   = ev_par && !rx_retry_enable;
  end

  // A set in the same cycle as a write-one clear wins
  always_comb begin
    st_d = st_q & ~((wr_stat ? I_WDATA : 32'h0000_0000) & W1C_MASK);
    st_d = (st_d | ev_vec) & W1C_MASK;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_q <= STAT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    stat_w             = st_q;
    stat_w[ST_TX_BUFFER_FULL]  = tx_full;
    stat_w[ST_TXEMPTY] = tx_empty;
    stat_w[ST_RX_BUFFER_FULL]  = rx_full;
    stat_w[ST_RX_BUFFER_EMPTY] = rx_empty;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(st_q & mask_q);
    end
  end

  // Unmapped addresses read zero; a data read pops the receive buffer
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        ADDR_DATA: O_RDATA <= {24'h00_0000, rx_head};
        ADDR_CTL:  O_RDATA <= ctl_q;
        ADDR_STAT: O_RDATA <= stat_w;
        ADDR_MASK: O_RDATA <= mask_q;
        default:   O_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  chk_tx_overrun_flag_set: assert property (wr_data && tx_full |=> st_q[ST_TX_OVERRUN_FLAG])
    else $error("transmit overrun not flagged");
  chk_tx_buffer_full_read: assert property (I_RD && I_ADDR == ADDR_STAT |=>
      O_RDATA[ST_TX_BUFFER_FULL] == ($past(tx_count) == 3'(BUF_DEPTH)))
    else $error("transmit full status wrong");
  chk_flag_hold: assert property (st_q[ST_BRK] && !(wr_stat && I_WDATA[ST_BRK])
      |=> st_q[ST_BRK])
    else $error("break flag lost without write one");
  chk_brk_set: assert property (ev_brk && !rx_retry_enable |=> st_q[ST_BRK])
    else $error("break not flagged");
  chk_brk_time: assert property ($rose(st_q[ST_BRK]) |->
      $past(low_cnt_q) == $past(char_clks))
    else $error("break flagged at wrong time");
  chk_frm_set: assert property (ev_char && !io_s && !rx_retry_enable
      |=> st_q[ST_FRM])
    else $error("stop bit error not flagged");
  chk_par_set: assert property (ev_char && (^rx_sh_q) && !rx_retry_enable
      |=> st_q[ST_PAR])
    else $error("parity error not flagged");
  chk_retry_quiet: assert property ($rose(st_q[ST_PAR]) || $rose(st_q[ST_FRM])
      || $rose(st_q[ST_BRK]) |-> !$past(rx_retry_enable))
    else $error("error flag set under retry");
  chk_rx_buffer_full_read: assert property (I_RD && I_ADDR == ADDR_STAT |=>
      O_RDATA[ST_RX_BUFFER_FULL] == ($past(rx_count) == 3'(BUF_DEPTH)))
    else $error("receive full status wrong");
  chk_rx_buffer_empty_read: assert property (rd_data && rx_count == 3'h1 && !rx_push ##1 !rx_push
      ##1 I_RD && I_ADDR == ADDR_STAT && !rx_push |=> O_RDATA[ST_RX_BUFFER_EMPTY])
    else $error("receive empty not shown after last read");
  chk_rx_overrun_flag_set: assert property (ev_char && rx_full |=> st_q[ST_RX_OVERRUN_FLAG] && rx_full)
    else $error("receive overrun not flagged");
  chk_rsvd_zero: assert property (I_RD && I_ADDR == ADDR_STAT |=>
      !O_RDATA[7] && !O_RDATA[3])
    else $error("reserved status bit nonzero");

  cov_tx_frame: cover property (tx_state_q == TX_SHIFT ##1 tx_state_q == TX_IDLE);
  cov_rx_par: cover property (ev_char && (^rx_sh_q));
  cov_rx_over: cover property (ev_char && rx_full);
  cov_break: cover property (ev_brk);
endmodule

// ===== bench/scs_card_model.sv
`timescale 1ns/1ns
module scs_card_model #(
  parameter int DIV = 4
) (
  input  wire logic i_clk,
  output logic      o_drive
);
  // ---------------------------------------------------------------
  // Card side of the open-drain data line
  // ---------------------------------------------------------------
  // A one releases the line to the pull-up; only zeros are driven.
  initial o_drive = 1'b1;

  task automatic bit_out(input logic b);
    o_drive <= b;
    repeat (DIV) @(posedge i_clk);
  endtask

  // Even parity; the error knobs let a scenario break the framing on purpose
  task automatic send_char(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(b[i]);
    end
    bit_out(^b ^ bad_par);
    bit_out(~bad_stop);
    repeat (2) bit_out(1'b1);
  endtask

  task automatic send_break(input int n);
    o_drive <= 1'b0;
    repeat (n) @(posedge i_clk);
    repeat (2) bit_out(1'b1);
  endtask
endmodule

// ===== bench/tb_scs_top.sv
`timescale 1ns/1ns
module tb_scs_top;
  import scs_pkg::*;

  localparam int DIV   = 4;
  localparam int LIMIT = 20000;

  logic              I_CLK;
  logic              I_SRST;
  logic [ADDR_W-1:0] I_ADDR;
  logic [31:0]       I_WDATA;
  logic              I_WR;
  logic              I_RD;
  logic [31:0]       O_RDATA;
  logic              O_IO_OUT;
  logic              O_IO_OE;
  logic              O_IRQ;
  logic              card_drive;
  wire logic         line;
  int                failures;
  int                n_tests;
  int                cycles;
  int                oe_cycles = 0;
  int                low_cycles = 0;
  logic [7:0]        rxb [5];

  // Pull-up line: either party may pull it low
  assign line = (O_IO_OE ? O_IO_OUT : 1'b1) & card_drive;

  scs_top i_scs_top (
    .I_CLK   (I_CLK),
    .I_SRST  (I_SRST),
    .I_ADDR  (I_ADDR),
    .I_WDATA (I_WDATA),
    .I_WR    (I_WR),
    .I_RD    (I_RD),
    .O_RDATA (O_RDATA),
    .I_IO_IN (line),
    .O_IO_OUT(O_IO_OUT),
    .O_IO_OE (O_IO_OE),
    .O_IRQ   (O_IRQ)
  );

  scs_card_model #(.DIV(DIV)) i_scs_card_model (
    .i_clk  (I_CLK),
    .o_drive(card_drive)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end

  task automatic stop_test();
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial cycles = 0;
  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (O_IO_OE === 1'b1) begin
      oe_cycles++;
      if (O_IO_OUT === 1'b0) begin
        low_cycles++;
      end
    end
    if (cycles == LIMIT) begin
      failures++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Register bus tasks, entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_CLK);
    I_WR    <= 1'b0;
    @(posedge I_CLK);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_CLK);
    I_RD   <= 1'b0;
    #1;
    v = O_RDATA;
    @(posedge I_CLK);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge I_CLK);
    #1;
    check("irq", {31'h0, O_IRQ}, {31'h0, exp});
  endtask

  // Three faulty events: bad parity, low stop bit, break; three bytes stored
  task automatic bad_events();
    i_scs_card_model.send_char(8'h5a, 1'b1, 1'b0);
    i_scs_card_model.send_char(8'h5a, 1'b0, 1'b1);
    i_scs_card_model.send_break(60);
  endtask

  task automatic drain3();
    logic [31:0] v;
    repeat (3) rd(ADDR_DATA, v);
    rd_chk(ADDR_STAT, 32'h0000_0202, "status drained");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int          k;
    failures = 0;
    n_tests  = 0;
    I_SRST   = 1'b1;
    I_ADDR   = '0;
    I_WDATA  = '0;
    I_WR     = 1'b0;
    I_RD     = 1'b0;
    rxb      = '{8'ha5, 8'h3c, 8'h01, 8'hff, 8'h77};
    repeat (6) @(posedge I_CLK);
    I_SRST <= 1'b0;
    @(posedge I_CLK);

    rd_chk(ADDR_STAT, 32'h0000_0202, "status at reset");
    rd_chk(ADDR_CTL, CTL_RST, "control at reset");
    rd_chk(4'h2, 32'h0, "unmapped read");
    wr(ADDR_STAT, 32'hffff_ffff);
    rd_chk(ADDR_STAT, 32'h0000_0202, "status after all ones");

    // Transmit buffer filled while disabled so nothing drains it
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_DATA, 32'h0000_0030 + i);
    end
    rd_chk(ADDR_STAT, 32'h0000_0002, "tx three bytes");
    wr(ADDR_DATA, 32'h0000_0033);
    rd_chk(ADDR_STAT, 32'h0000_0402, "tx four bytes");
    wr(ADDR_DATA, 32'h0000_0034);
    rd_chk(ADDR_STAT, 32'h0000_0502, "tx overrun");
    irq_chk(1'b0);
    wr(ADDR_MASK, 32'h0000_0100);
    irq_chk(1'b1);
    wr(ADDR_STAT, 32'hffff_feff);
    rd_chk(ADDR_STAT, 32'h0000_0502, "overrun kept on zero");
    wr(ADDR_STAT, 32'h0000_0100);
    irq_chk(1'b0);
    rd_chk(ADDR_STAT, 32'h0000_0402, "overrun cleared");

    // Enable at four clocks per bit and let the buffered bytes go out
    wr(ADDR_CTL, 32'h0000_0041);
    k = 0;
    do begin
      rd(ADDR_STAT, v);
      k++;
    end while (v[ST_TXEMPTY] !== 1'b1 && k < 200);
    k = 0;
    while (O_IO_OE !== 1'b0 && k < 200) begin
      @(posedge I_CLK);
      k++;
    end
    rd_chk(ADDR_STAT, 32'h0000_0202, "tx drained");
    // Four frames of eleven bit times; the fifth byte was dropped
    check("tx drive cycles", oe_cycles, 32'(4 * 11 * DIV));
    // Low bits of 0x30..0x33 with start and even parity: 8+6+6+6
    check("tx low cycles", low_cycles, 32'(26 * DIV));

    // Receive path: fill, overrun, drain
    for (int i = 0; i < 3; i++) begin
      i_scs_card_model.send_char(rxb[i], 1'b0, 1'b0);
    end
    rd_chk(ADDR_STAT, 32'h0000_0200, "rx three bytes");
    i_scs_card_model.send_char(rxb[3], 1'b0, 1'b0);
    rd_chk(ADDR_STAT, 32'h0000_0204, "rx four bytes");
    i_scs_card_model.send_char(rxb[4], 1'b0, 1'b0);
    rd_chk(ADDR_STAT, 32'h0000_0205, "rx overrun");
    for (int i = 0; i < 4; i++) begin
      rd_chk(ADDR_DATA, {24'h0, rxb[i]}, "rx byte");
    end
    rd_chk(ADDR_STAT, 32'h0000_0203, "rx empty after reads");
    wr(ADDR_STAT, 32'h0000_0001);
    rd_chk(ADDR_STAT, 32'h0000_0202, "rx overrun cleared");

    // Line faults, one flag at a time
    i_scs_card_model.send_char(8'h5a, 1'b1, 1'b0);
    rd_chk(ADDR_STAT, 32'h0000_0210, "parity error");
    i_scs_card_model.send_char(8'h5a, 1'b0, 1'b1);
    rd_chk(ADDR_STAT, 32'h0000_0230, "stop bit error");
    i_scs_card_model.send_break(60);
    rd_chk(ADDR_STAT, 32'h0000_0270, "break");
    wr(ADDR_STAT, 32'h0000_0070);
    rd_chk(ADDR_STAT, 32'h0000_0200, "line errors cleared");
    drain3();

    // Retry enabled: the same faults leave the flags alone
    wr(ADDR_CTL, 32'h0008_0041);
    bad_events();
    rd_chk(ADDR_STAT, 32'h0000_0200, "retry suppresses flags");
    drain3();
    stop_test();
  end
endmodule
